// ---- scuc_pkg.sv ----
// constants for the sensor configuration and serial command block
package scuc_pkg;
  // clock and link timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_SLOW = 2400;
  localparam int BAUD_FAST = 9600;
  localparam int BIT_SLOW_CYCLES = CLK_HZ / BAUD_SLOW;
  localparam int BIT_FAST_CYCLES = CLK_HZ / BAUD_FAST;
  localparam int FRAME_LAST_BIT = 9;
  // memory sizes
  localparam int CFG_DEPTH = 48;
  localparam int WM_DEPTH = 64;
  // command field and codes
  localparam logic [1:0] CMD_RD_WM = 2'h3;
  localparam logic [1:0] CMD_RD_CFG = 2'h2;
  localparam logic [1:0] CMD_WR_CFG = 2'h1;
  localparam logic [1:0] CMD_WR_WM = 2'h0;
  localparam logic [5:0] ADDR_RESET_CMD = 6'h3f;
  localparam logic [5:0] CFG_ADDR_LAST = 6'h2f;
  localparam logic [7:0] ACK_BYTE = 8'hbc;
  localparam logic [7:0] CHECKSUM_GOOD = 8'hff;
  // configuration byte addresses
  localparam logic [5:0] CFG_MODE = 6'h00;
  localparam logic [5:0] CFG_GAP = 6'h1a;
  localparam logic [5:0] CFG_ALM_LO_TRIG = 6'h1b;
  localparam logic [5:0] CFG_ALM_LO_OUT = 6'h1c;
  localparam logic [5:0] CFG_ALM_HI_TRIG = 6'h1d;
  localparam logic [5:0] CFG_ALM_HI_OUT = 6'h1e;
  localparam logic [5:0] CFG_SRC_CTRL = 6'h1f;
  localparam logic [5:0] CFG_LVL_1 = 6'h1c;
  localparam logic [5:0] CFG_LVL_2 = 6'h1d;
  localparam logic [5:0] CFG_LVL_3 = 6'h1e;
  localparam logic [5:0] CFG_FAULT_HI = 6'h28;
  localparam logic [5:0] CFG_FAULT_LO = 6'h29;
  localparam logic [5:0] CFG_CUR_HI = 6'h2a;
  localparam logic [5:0] CFG_CUR_LO = 6'h2b;
  // live working-memory locations, 10 bits left justified in 16
  localparam logic [5:0] WM_TEMP_HI = 6'h3a;
  localparam logic [5:0] WM_TEMP_LO = 6'h3b;
  localparam logic [5:0] WM_GAIN_HI = 6'h3c;
  localparam logic [5:0] WM_GAIN_LO = 6'h3d;
  // operating_mode_flags bit positions and reset value
  localparam int MODE_CHECKSUM = 7;
  localparam int MODE_DIGITAL = 6;
  localparam int MODE_ALARM = 5;
  localparam int MODE_LEVEL = 4;
  localparam int MODE_FAST = 3;
  localparam int MODE_VOLT = 2;
  localparam int MODE_EXT_TEMP = 1;
  localparam int MODE_CUR = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // source selector codes
  localparam logic [3:0] SRC_TEMP = 4'h2;
  localparam logic [3:0] SRC_INAMP = 4'h6;
  localparam logic [3:0] SRC_GAIN = 4'h0;
  localparam logic [3:0] SRC_VOUT = 4'h3;
  localparam logic [3:0] SRC_AUX1 = 4'h4;
  localparam logic [3:0] SRC_AUX2 = 4'h5;
  // command states, gray coded along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ECHO = 3'b001, ST_WAIT_DATA = 3'b011, ST_ACK1 = 3'b010,
    ST_ACK2 = 3'b110, ST_REPLY = 3'b111, ST_RST_MSG = 3'b101, ST_RST_WAIT = 3'b100
  } scuc_state_t;
endpackage

// ---- scuc_top.sv ----
// serial command interpreter and stored-setting decoder of the sensor conditioner
// Behaviour
// - upper gap nibble 15,14,12,10,8,6 gives fixed, one to five signal gaps
// - lower gap nibble 0,5,8,11 gives fixed, two, three, four temperature gaps
// - active alarm forces output to programmed level beyond a limit
// - alarm uses low trigger, low output, high trigger, high output, control
// - alarm bytes compare with upper eight bits of ten-bit measurement
// - control byte 31 upper nibble selects alarm source from six codes
// - level steering uses selector byte plus three eight-bit transition levels
// - level steering enabled disables alarm limiting
// - level steering accepts only temperature, input amp, gain, voltage codes
// - mode bit 7 enables checksum; failure drives output from bytes 40, 41
// - mode bit 6 picks analog or digital; host sets digital with both stages
// - mode bit 5: below low or above high trigger sets override level
// - mode bit 4 makes aux pins two-bit output, else analog inputs
// - mode bits 3,2,1 give fast baud, voltage stage, external sensor
// - mode bit 0 current stage; both stages digital give fixed current value
// - command byte: two-bit command, six-bit address
// - codes 11 read working, 10 read config, 01 write config, 00 write working
// - working addresses 0-63, config 0-47, config read 63 resets
// - working reads show live temperature and gain stage values
// - a read answers one byte holding the addressed value
// - write echoes command, takes data, confirms with two acknowledge bytes
// - reset command sends acknowledge byte just before resetting
// - frames are start 0, eight data bits, stop 1
`timescale 1ns/1ns
`default_nettype none
module scuc_top
  import scuc_pkg::*;
#(
  parameter int SLOW_BIT_CYCLES = BIT_SLOW_CYCLES,
  parameter int FAST_BIT_CYCLES = BIT_FAST_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // serial link
  input wire logic uart_rx_pin,
  output logic uart_tx_pin,
  // digitized measurements, same clock
  input wire logic [9:0] temperature_signal,
  input wire logic [9:0] input_amp_signal,
  input wire logic [9:0] gain_stage_signal,
  input wire logic [9:0] voltage_output_signal,
  input wire logic [9:0] aux_one_level,
  input wire logic [9:0] aux_two_level,
  input wire logic [9:0] conditioned_value,
  // conditioned output
  output logic [9:0] output_value,
  output logic digital_output_override,
  output logic checksum_fail,
  output logic soft_reset_pulse,
  // auxiliary pins
  output logic aux_pin_one_o,
  output logic aux_pin_one_oe,
  output logic aux_pin_two_o,
  output logic aux_pin_two_oe,
  // decoded settings
  output logic digital_mode,
  output logic voltage_stage_en,
  output logic current_stage_en,
  output logic current_fixed_active,
  output logic [9:0] current_fixed_value,
  output logic external_temp_sel,
  output logic fast_baud,
  output logic [2:0] signal_gap_count,
  output logic [2:0] temp_gap_count,
  output logic gap_code_valid
);

  // nibble to signal gaps, zero means fixed
  function automatic logic [3:0] sig_gaps(input logic [3:0] c);
    case (c)
      4'hf: sig_gaps = 4'h8;
      4'he: sig_gaps = 4'h9;
      4'hc: sig_gaps = 4'ha;
      4'ha: sig_gaps = 4'hb;
      4'h8: sig_gaps = 4'hc;
      4'h6: sig_gaps = 4'hd;
      default: sig_gaps = 4'h0;
    endcase
  endfunction

  // nibble to temperature ranges, one means fixed
  function automatic logic [3:0] tmp_gaps(input logic [3:0] c);
    case (c)
      4'h0: tmp_gaps = 4'h9;
      4'h5: tmp_gaps = 4'ha;
      4'h8: tmp_gaps = 4'hb;
      4'hb: tmp_gaps = 4'hc;
      default: tmp_gaps = 4'h0;
    endcase
  endfunction

  // source selector, bit 10 flags a usable code
  function automatic logic [10:0] pick_src(input logic [3:0] c, input logic allow_aux,
      input logic [9:0] t, input logic [9:0] ia, input logic [9:0] g, input logic [9:0] v,
      input logic [9:0] a1, input logic [9:0] a2);
    case (c)
      SRC_TEMP: pick_src = {1'b1, t};
      SRC_INAMP: pick_src = {1'b1, ia};
      SRC_GAIN: pick_src = {1'b1, g};
      SRC_VOUT: pick_src = {1'b1, v};
      SRC_AUX1: pick_src = {allow_aux, a1};
      SRC_AUX2: pick_src = {allow_aux, a2};
      default: pick_src = {1'b0, 10'h000};
    endcase
  endfunction

  logic soft_rst_reg, soft_rst_next;
  logic rst_all;
  assign rst_all = srst | soft_rst_reg;

  // settings shadow, loaded at the end of start-up
  logic [7:0] mode_reg, mode_next;
  logic [7:0] cfg_mem [CFG_DEPTH];
  logic [7:0] wm_mem [WM_DEPTH];
  logic [13:0] bit_cycles;
  assign bit_cycles = mode_reg[MODE_FAST] ? 14'(FAST_BIT_CYCLES - 1) : 14'(SLOW_BIT_CYCLES - 1);

  // receive synchroniser and framer
  logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
  logic rx_busy_reg, rx_busy_next;
  logic [13:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_valid_reg, rx_valid_next;
  always_comb begin
    rx_busy_next = rx_busy_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_data_next = rx_data_reg;
    rx_valid_next = 1'b0;
    if (!rx_busy_reg) begin
      if (rx_prev_reg && !rx_s2_reg) begin
        rx_busy_next = 1'b1;
        rx_cnt_next = {1'b0, bit_cycles[13:1]};
        rx_bit_next = 4'h0;
      end
    end else if (rx_cnt_reg != 14'h0000) begin
      rx_cnt_next = rx_cnt_reg - 14'h0001;
    end else begin
      rx_cnt_next = bit_cycles;
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0) begin
        rx_busy_next = ~rx_s2_reg;
      end else if (rx_bit_reg == 4'(FRAME_LAST_BIT)) begin
        rx_busy_next = 1'b0;
        rx_valid_next = rx_s2_reg;
      end else begin
        rx_data_next = {rx_s2_reg, rx_data_reg[7:1]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    rx_s1_reg <= srst ? 1'b1 : uart_rx_pin;
    rx_s2_reg <= srst ? 1'b1 : rx_s1_reg;
    if (rst_all) begin
      rx_prev_reg <= 1'b1;
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 14'h0000;
      rx_bit_reg <= 4'h0;
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_s2_reg;
      rx_busy_reg <= rx_busy_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_data_reg <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  // transmit framer
  logic tx_start;
  logic [7:0] tx_byte;
  logic tx_busy_reg, tx_busy_next;
  logic [13:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_shift_reg, tx_shift_next;
  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    if (!tx_busy_reg) begin
      if (tx_start) begin
        tx_busy_next = 1'b1;
        tx_cnt_next = bit_cycles;
        tx_bit_next = 4'h0;
        tx_shift_next = {1'b1, tx_byte, 1'b0};
      end
    end else if (tx_cnt_reg != 14'h0000) begin
      tx_cnt_next = tx_cnt_reg - 14'h0001;
    end else begin
      tx_cnt_next = bit_cycles;
      tx_bit_next = tx_bit_reg + 4'h1;
      tx_shift_next = {1'b1, tx_shift_reg[9:1]};
      tx_busy_next = (tx_bit_reg != 4'(FRAME_LAST_BIT));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 14'h0000;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 10'h3ff;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
    end
  end
  assign uart_tx_pin = tx_shift_reg[0];

  // start-up scan: checksum and shadow load
  logic init_busy_reg, init_busy_next;
  logic [5:0] init_idx_reg, init_idx_next;
  logic [7:0] sum_reg, sum_next;
  logic sum_bad_reg, sum_bad_next;
  always_comb begin
    init_busy_next = init_busy_reg;
    init_idx_next = init_idx_reg;
    sum_next = sum_reg;
    sum_bad_next = sum_bad_reg;
    mode_next = mode_reg;
    if (init_busy_reg) begin
      sum_next = sum_reg + cfg_mem[init_idx_reg];
      init_idx_next = init_idx_reg + 6'h01;
      if (init_idx_reg == CFG_ADDR_LAST) begin
        init_busy_next = 1'b0;
        mode_next = cfg_mem[CFG_MODE];
        sum_bad_next = cfg_mem[CFG_MODE][MODE_CHECKSUM] && (sum_next != CHECKSUM_GOOD);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      init_busy_reg <= 1'b1;
      init_idx_reg <= 6'h00;
      sum_reg <= 8'h00;
      sum_bad_reg <= 1'b0;
      mode_reg <= MODE_RESET;
    end else begin
      init_busy_reg <= init_busy_next;
      init_idx_reg <= init_idx_next;
      sum_reg <= sum_next;
      sum_bad_reg <= sum_bad_next;
      mode_reg <= mode_next;
    end
  end

  // command interpreter
  scuc_state_t st_reg, st_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] reply_reg, reply_next;
  logic cfg_we, wm_we;
  logic [7:0] rd_cfg, rd_wm;
  always_comb begin
    case (rx_data_reg[5:0])
      WM_TEMP_HI: rd_wm = temperature_signal[9:2];
      WM_TEMP_LO: rd_wm = {temperature_signal[1:0], 6'h00};
      WM_GAIN_HI: rd_wm = gain_stage_signal[9:2];
      WM_GAIN_LO: rd_wm = {gain_stage_signal[1:0], 6'h00};
      default: rd_wm = wm_mem[rx_data_reg[5:0]];
    endcase
    rd_cfg = (rx_data_reg[5:0] <= CFG_ADDR_LAST) ? cfg_mem[rx_data_reg[5:0]] : 8'h00;
  end

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    reply_next = reply_reg;
    soft_rst_next = 1'b0;
    tx_start = 1'b0;
    tx_byte = ACK_BYTE;
    cfg_we = 1'b0;
    wm_we = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        if (rx_valid_reg && !init_busy_reg) begin
          cmd_next = rx_data_reg;
          case (rx_data_reg[7:6])
            CMD_RD_WM: begin
              reply_next = rd_wm;
              st_next = ST_REPLY;
            end
            CMD_RD_CFG: begin
              reply_next = rd_cfg;
              if (rx_data_reg[5:0] == ADDR_RESET_CMD) begin
                st_next = ST_RST_MSG;
              end else if (rx_data_reg[5:0] <= CFG_ADDR_LAST) begin
                st_next = ST_REPLY;
              end
            end
            CMD_WR_CFG: begin
              if (rx_data_reg[5:0] <= CFG_ADDR_LAST) begin
                st_next = ST_ECHO;
              end
            end
            default: st_next = ST_ECHO;
          endcase
        end
      end
      ST_ECHO: begin
        tx_byte = cmd_reg;
        tx_start = !tx_busy_reg;
        if (!tx_busy_reg) begin
          st_next = ST_WAIT_DATA;
        end
      end
      ST_WAIT_DATA: begin
        if (rx_valid_reg) begin
          cfg_we = (cmd_reg[7:6] == CMD_WR_CFG);
          wm_we = (cmd_reg[7:6] == CMD_WR_WM);
          st_next = ST_ACK1;
        end
      end
      ST_ACK1: begin
        tx_start = !tx_busy_reg;
        if (!tx_busy_reg) begin
          st_next = ST_ACK2;
        end
      end
      ST_ACK2: begin
        tx_start = !tx_busy_reg;
        if (!tx_busy_reg) begin
          st_next = ST_IDLE;
        end
      end
      ST_REPLY: begin
        tx_byte = reply_reg;
        tx_start = !tx_busy_reg;
        if (!tx_busy_reg) begin
          st_next = ST_IDLE;
        end
      end
      ST_RST_MSG: begin
        tx_start = !tx_busy_reg;
        if (!tx_busy_reg) begin
          st_next = ST_RST_WAIT;
        end
      end
      ST_RST_WAIT: begin
        if (!tx_busy_reg) begin
          soft_rst_next = 1'b1;
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    soft_rst_reg <= srst ? 1'b0 : soft_rst_next;
    if (rst_all) begin
      st_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      reply_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      reply_reg <= reply_next;
    end
  end
  assign soft_reset_pulse = soft_rst_reg;

  // storage, kept across the reset command
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_mem[i] <= 8'h00;
      end
      for (int i = 0; i < WM_DEPTH; i++) begin
        wm_mem[i] <= 8'h00;
      end
    end else begin
      if (cfg_we) begin
        cfg_mem[cmd_reg[5:0]] <= rx_data_reg;
      end
      if (wm_we) begin
        wm_mem[cmd_reg[5:0]] <= rx_data_reg;
      end
    end
  end

  // setting decode and output limiting
  logic [3:0] sg, tg;
  logic [10:0] alm_src, lvl_src;
  logic alarm_on, alm_lo, alm_hi;
  logic [1:0] lvl_code;
  logic [9:0] out_next;
  logic ovr_next;
  always_comb begin
    sg = sig_gaps(cfg_mem[CFG_GAP][7:4]);
    tg = tmp_gaps(cfg_mem[CFG_GAP][3:0]);
    alm_src = pick_src(cfg_mem[CFG_SRC_CTRL][7:4], 1'b1, temperature_signal, input_amp_signal,
        gain_stage_signal, voltage_output_signal, aux_one_level, aux_two_level);
    lvl_src = pick_src(cfg_mem[CFG_SRC_CTRL][7:4], 1'b0, temperature_signal, input_amp_signal,
        gain_stage_signal, voltage_output_signal, aux_one_level, aux_two_level);
    alarm_on = mode_reg[MODE_ALARM] && !mode_reg[MODE_LEVEL] && alm_src[10];
    alm_lo = alm_src[9:2] < cfg_mem[CFG_ALM_LO_TRIG];
    alm_hi = alm_src[9:2] > cfg_mem[CFG_ALM_HI_TRIG];
    lvl_code = 2'(lvl_src[9:2] >= cfg_mem[CFG_LVL_1]) + 2'(lvl_src[9:2] >= cfg_mem[CFG_LVL_2]) +
        2'(lvl_src[9:2] >= cfg_mem[CFG_LVL_3]);
    out_next = conditioned_value;
    ovr_next = 1'b0;
    if (sum_bad_reg) begin
      out_next = {cfg_mem[CFG_FAULT_HI][1:0], cfg_mem[CFG_FAULT_LO]};
    end else if (alarm_on && alm_lo) begin
      out_next = {cfg_mem[CFG_ALM_LO_OUT], 2'b00};
      ovr_next = 1'b1;
    end else if (alarm_on && alm_hi) begin
      out_next = {cfg_mem[CFG_ALM_HI_OUT], 2'b00};
      ovr_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      output_value <= 10'h000;
      digital_output_override <= 1'b0;
      aux_pin_one_o <= 1'b0;
      aux_pin_two_o <= 1'b0;
      signal_gap_count <= 3'h0;
      temp_gap_count <= 3'h0;
      gap_code_valid <= 1'b0;
      current_fixed_value <= 10'h000;
    end else begin
      output_value <= out_next;
      digital_output_override <= ovr_next;
      aux_pin_one_o <= mode_reg[MODE_LEVEL] & lvl_src[10] & lvl_code[0];
      aux_pin_two_o <= mode_reg[MODE_LEVEL] & lvl_src[10] & lvl_code[1];
      signal_gap_count <= sg[2:0];
      temp_gap_count <= tg[2:0];
      gap_code_valid <= sg[3] & tg[3];
      current_fixed_value <= {cfg_mem[CFG_CUR_HI][1:0], cfg_mem[CFG_CUR_LO]};
    end
  end

  // mode flags straight from the loaded shadow, checksum flag from the start-up scan
  assign aux_pin_one_oe = mode_reg[MODE_LEVEL];
  assign aux_pin_two_oe = mode_reg[MODE_LEVEL];
  assign digital_mode = mode_reg[MODE_DIGITAL];
  assign fast_baud = mode_reg[MODE_FAST];
  assign voltage_stage_en = mode_reg[MODE_VOLT];
  assign external_temp_sel = mode_reg[MODE_EXT_TEMP];
  assign current_stage_en = mode_reg[MODE_CUR];
  assign current_fixed_active = mode_reg[MODE_CUR] & mode_reg[MODE_VOLT] & mode_reg[MODE_DIGITAL];
  assign checksum_fail = sum_bad_reg;

endmodule
`default_nettype wire

// ---- scuc_assertions.sv ----
// port assertions for the serial command block
`timescale 1ns/1ns
`default_nettype none
module scuc_checker #(
  parameter int SLOW_BIT_CYCLES = 16,
  parameter int FAST_BIT_CYCLES = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // watched ports
  input wire logic uart_tx_pin,
  input wire logic [9:0] conditioned_value,
  input wire logic [9:0] output_value,
  input wire logic digital_output_override,
  input wire logic checksum_fail,
  input wire logic soft_reset_pulse,
  input wire logic aux_pin_one_oe,
  input wire logic aux_pin_two_oe,
  input wire logic digital_mode,
  input wire logic voltage_stage_en,
  input wire logic current_stage_en,
  input wire logic current_fixed_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // a low level on the line lasts at least half a slow bit
  sequence tx_low_hold;
    !uart_tx_pin [*8];
  endsequence
  // the reset pulse comes on an idle line and lasts one cycle
  sequence pulse_then_gone;
    uart_tx_pin ##1 !soft_reset_pulse;
  endsequence
  a_tx_idle_reset: assert property (
    $fell(srst) |-> uart_tx_pin) else $error("tx not idle after reset");
  a_start_bit_len: assert property (
    $fell(uart_tx_pin) |-> tx_low_hold) else $error("tx low too short");
  a_aux_pin_pair: assert property (
    aux_pin_one_oe == aux_pin_two_oe) else $error("aux enables differ");
  a_steer_blocks_alarm: assert property (
    aux_pin_one_oe |-> !digital_output_override) else $error("alarm with steering");
  a_fixed_current: assert property (
    current_fixed_active == (digital_mode && voltage_stage_en && current_stage_en))
    else $error("fixed current decode wrong");
  a_reset_pulse_one: assert property (
    soft_reset_pulse |-> pulse_then_gone) else $error("reset pulse wrong");
  a_alarm_level_align: assert property (
    digital_output_override && !checksum_fail |-> output_value[1:0] == 2'h0)
    else $error("alarm level not aligned");
  a_pass_through: assert property (
    !digital_output_override && !checksum_fail && !$past(srst) && !$past(soft_reset_pulse)
    |-> output_value == $past(conditioned_value)) else $error("output not passed through");
endmodule
bind scuc_top scuc_checker #(.SLOW_BIT_CYCLES(SLOW_BIT_CYCLES), .FAST_BIT_CYCLES(FAST_BIT_CYCLES)) i_chk (
  .sys_clk, .srst, .uart_tx_pin, .conditioned_value, .output_value, .digital_output_override,
  .checksum_fail, .soft_reset_pulse, .aux_pin_one_oe, .aux_pin_two_oe, .digital_mode,
  .voltage_stage_en, .current_stage_en, .current_fixed_active);
`default_nettype wire

// ---- scuc_host_model.sv ----
// serial host model that sends commands and collects replies
`timescale 1ns/1ns
`default_nettype none
module scuc_host_model (
  // clock
  input wire logic sys_clk,
  // serial link
  input wire logic uart_tx_pin,
  output logic uart_rx_pin
);
  int bit_cyc = 16;
  // line idles high
  initial uart_rx_pin = 1'b1;
  // one frame, start 0, eight bits lsb first, stop 1
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 10; i++) begin
      uart_rx_pin = fr[i];
      repeat (bit_cyc) @(posedge sys_clk);
      #1;
    end
  endtask
  // wait a bounded time for a frame, sample each bit at its centre;
  // return half a bit after the stop centre so a frame sent right behind is not missed
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    logic [9:0] fr;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (uart_tx_pin !== 1'b0 && n < 40 * bit_cyc) begin
      @(posedge sys_clk);
      n++;
    end
    if (n < 40 * bit_cyc) begin
      repeat (bit_cyc / 2) @(posedge sys_clk);
      for (int i = 0; i < 10; i++) begin
        fr[i] = uart_tx_pin;
        repeat (i < 9 ? bit_cyc : bit_cyc / 2) @(posedge sys_clk);
      end
      b = fr[8:1];
      ok = (fr[0] === 1'b0) && (fr[9] === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// ---- sensor_config_uart_commands_bench.sv ----
// bench for the serial command block
`timescale 1ns/1ns
`default_nettype none
module sensor_config_uart_commands_bench import scuc_pkg::*;;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] sv [6] = '{10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200};
  logic [9:0] conditioned_value = 10'h155;
  logic uart_rx_pin, uart_tx_pin, ovr, checksum_fail, soft_reset_pulse, aux_pin_one_o, aux_pin_two_o;
  logic aux_pin_one_oe, digital_mode, voltage_stage_en, current_stage_en, current_fixed_active;
  logic external_temp_sel, fast_baud, gap_code_valid;
  logic [9:0] output_value, current_fixed_value;
  logic [2:0] signal_gap_count, temp_gap_count;
  logic [7:0] b;
  bit ok;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_pulse = 0;
  logic [7:0] gap_code [8] = '{8'hf0, 8'he5, 8'hc8, 8'hfb, 8'ha0, 8'h80, 8'h60, 8'h71};
  logic [6:0] gap_exp [8] = '{7'h41, 7'h4a, 7'h53, 7'h44, 7'h59, 7'h61, 7'h69, 7'h00};
  logic [7:0] alm [5] = '{8'h40, 8'h11, 8'hc0, 8'hee, {SRC_TEMP, 4'h0}};
  logic [3:0] src_code [6] = '{SRC_TEMP, SRC_INAMP, SRC_GAIN, SRC_VOUT, SRC_AUX1, SRC_AUX2};
  logic [9:0] lvl_in [4] = '{10'h000, 10'h0fc, 10'h300, 10'h3fc};
  // clock, cycle ceiling and reset pulse count
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    n_pulse += (soft_reset_pulse === 1'b1);
    if (cyc == 60000) begin
      miscompares++;
      $display("timeout");
      stop_test();
    end
  end
  scuc_top #(.SLOW_BIT_CYCLES(16), .FAST_BIT_CYCLES(8)) i_dut (
    .sys_clk, .srst, .uart_rx_pin, .uart_tx_pin, .temperature_signal(sv[0]), .input_amp_signal(sv[1]),
    .gain_stage_signal(sv[2]), .voltage_output_signal(sv[3]), .aux_one_level(sv[4]), .aux_two_level(sv[5]),
    .conditioned_value, .output_value, .digital_output_override(ovr), .checksum_fail, .soft_reset_pulse,
    .aux_pin_one_o, .aux_pin_one_oe, .aux_pin_two_o, .aux_pin_two_oe(), .digital_mode, .voltage_stage_en,
    .current_stage_en, .current_fixed_active, .current_fixed_value, .external_temp_sel, .fast_baud,
    .signal_gap_count, .temp_gap_count, .gap_code_valid);
  scuc_host_model i_host (.sys_clk, .uart_tx_pin, .uart_rx_pin);
  // compare and count
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expect_byte(input logic [7:0] exp);
    i_host.recv_byte(b, ok);
    chk("tx frame", {9'h0, ok}, 10'h001);
    chk("tx byte", {2'h0, b}, {2'h0, exp});
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    i_host.send_byte(cmd);
    expect_byte(cmd);
    i_host.send_byte(d);
    expect_byte(ACK_BYTE);
    expect_byte(ACK_BYTE);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    i_host.send_byte(cmd);
    expect_byte(exp);
  endtask
  task automatic soft_reset;
    int p;
    p = n_pulse;
    rd({CMD_RD_CFG, ADDR_RESET_CMD}, ACK_BYTE);
    repeat (60) @(posedge sys_clk);
    chk("reset pulses", 10'(n_pulse - p), 10'h001);
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 srst = 1'b0;
    repeat (60) @(posedge sys_clk);
    chk("mode reset", {5'h0, digital_mode, fast_baud, voltage_stage_en, current_stage_en, aux_pin_one_oe}, 10'h0);
    wr({CMD_WR_CFG, 6'h05}, 8'h5a);
    rd({CMD_RD_CFG, 6'h05}, 8'h5a);
    wr({CMD_WR_WM, 6'h3f}, 8'ha5);
    rd({CMD_RD_WM, 6'h3f}, 8'ha5);
    #1 sv[0] = 10'h2c3;
    rd({CMD_RD_WM, WM_TEMP_LO}, {sv[0][1:0], 6'h00});
    rd({CMD_RD_WM, WM_GAIN_HI}, sv[2][9:2]);
    i_host.send_byte({CMD_WR_CFG, 6'h30});
    i_host.recv_byte(b, ok);
    chk("no echo", {9'h0, ok}, 10'h000);
    $display("memory test done");
    // every gap code, kept within shared storage, then a bad code
    for (int i = 0; i < 8; i++) begin
      wr({CMD_WR_CFG, CFG_GAP}, gap_code[i]);
      repeat (4) @(posedge sys_clk);
      chk("gap decode", {3'h0, gap_code_valid, signal_gap_count, temp_gap_count}, {3'h0, gap_exp[i]});
    end
    $display("gap test done");
    // alarm bytes in order, then mode with alarm on
    for (int i = 0; i < 5; i++) begin
      wr({CMD_WR_CFG, CFG_ALM_LO_TRIG + 6'(i)}, alm[i]);
    end
    wr({CMD_WR_CFG, CFG_MODE}, 8'h20);
    soft_reset();
    #1 sv[0] = 10'h0fc;
    repeat (4) @(posedge sys_clk);
    chk("low alarm", {ovr, output_value[9:1]}, {1'b1, 8'h11, 1'b0});
    #1 sv[0] = 10'h304;
    repeat (4) @(posedge sys_clk);
    chk("high alarm", {ovr, output_value[9:1]}, {1'b1, 8'hee, 1'b0});
    #1 sv[0] = 10'h300;
    repeat (4) @(posedge sys_clk);
    chk("at limit", {ovr, output_value[9:1]}, {1'b0, conditioned_value[9:1]});
    for (int k = 0; k < 6; k++) begin
      wr({CMD_WR_CFG, CFG_SRC_CTRL}, {src_code[k], 4'h0});
      #1 sv[k] = 10'h0fc;
      repeat (4) @(posedge sys_clk);
      chk("alarm source", {9'h0, ovr}, 10'h001);
      #1 sv[k] = 10'h200;
    end
    $display("alarm test done");
    // level steering on the gain stage, alarm must stay off
    wr({CMD_WR_CFG, CFG_SRC_CTRL}, {SRC_GAIN, 4'h0});
    wr({CMD_WR_CFG, CFG_MODE}, 8'h30);
    soft_reset();
    for (int i = 0; i < 4; i++) begin
      #1 sv[2] = lvl_in[i];
      repeat (4) @(posedge sys_clk);
      chk("level code", {6'h0, aux_pin_one_oe, ovr, aux_pin_two_o, aux_pin_one_o}, 10'(i + 8));
    end
    wr({CMD_WR_CFG, CFG_SRC_CTRL}, {SRC_AUX1, 4'h0});
    repeat (4) @(posedge sys_clk);
    chk("bad selector", {8'h0, aux_pin_two_o, aux_pin_one_o}, 10'h000);
    $display("level test done");
    // alarm unused from here, so its five bytes go to zero; fault and fixed current values set
    for (int i = 0; i < 5; i++) begin
      wr({CMD_WR_CFG, CFG_ALM_LO_TRIG + 6'(i)}, 8'h00);
    end
    wr({CMD_WR_CFG, CFG_FAULT_LO}, 8'h96);
    wr({CMD_WR_CFG, CFG_CUR_LO}, 8'h3c);
    // all flags on except alarm and level steering: digital needed with both stages
    wr({CMD_WR_CFG, CFG_MODE}, 8'hcf);
    soft_reset();
    chk("mode flags", {3'h0, checksum_fail, digital_mode, fast_baud, voltage_stage_en, external_temp_sel,
      current_stage_en, current_fixed_active}, 10'h07f);
    chk("fault value", output_value, 10'h096);
    chk("fixed current", current_fixed_value, 10'h03c);
    i_host.bit_cyc = 8;
    rd({CMD_RD_CFG, 6'h05}, 8'h5a);
    $display("mode test done");
    stop_test();
  end
endmodule
`default_nettype wire
